/* rtl/memory_map_address_decoder.sv */
`timescale 1ns/1ps
module memory_map_address_decoder #(
	parameter logic [23:0] IRAM_BASE = 24'h00F600,
	parameter logic [23:0] SFR_BASE = 24'h00FE00,
	parameter logic [23:0] EXTENDED_FUNCTION_REGS_BASE = 24'h00F000,
	parameter logic [23:0] BIT_IRAM_BASE = 24'h00FD00,
	parameter logic [23:0] BIT_SFR_BASE = 24'h00FF00,
	parameter logic [23:0] BIT_EXTENDED_FUNCTION_REGS_BASE = 24'h00F100
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_req,
	input wire logic [23:0] i_addr,
	input wire logic i_word,
	input wire logic i_write,
	input wire logic i_bit_access,
	input wire logic i_stack_access,
	input wire logic i_gpr_access,
	input wire logic [3:0] i_gpr_num,
	input wire logic [23:0] i_context_ptr,
	input wire logic [15:0] i_system_config_reg,
	input wire logic [3:0] i_window_enable,
	input wire logic [47:0] i_window_base,
	input wire logic [47:0] i_window_mask,
	input wire logic i_ext_done,
	output logic [2:0] o_target,
	output logic [23:0] o_addr,
	output logic o_word,
	output logic o_write,
	output logic o_bit_access,
	output logic [2:0] o_bus_config_sel,
	output logic [4:0] o_chip_select,
	output logic [1:0] o_wait_states,
	output logic o_demux,
	output logic [3:0] o_segment_lines,
	output logic o_busy,
	output logic o_ack,
	output logic o_error
);
	import memory_map_pkg::*;

	localparam int CAN_DLY = CAN_ACCESS_CYC;
	localparam logic [4:0] EXTENSION_RAM_CNT = 5'(EXTENSION_RAM_ACCESS_CYC - 1);
	localparam logic [4:0] CAN_CNT = 5'(CAN_ACCESS_CYC - 1);
	localparam logic [4:0] ONCHIP_CNT = 5'(ONCHIP_ACCESS_CYC - 1);

	typedef struct packed {
		state_t state;
		logic [4:0] count;
		target_t target;
		logic [23:0] addr;
		logic word;
		logic write;
		logic bit_acc;
		logic [2:0] bus_cfg;
		logic [4:0] cs;
		logic [1:0] wait_states;
		logic demux;
		logic [3:0] seg_lines;
		logic busy;
		logic ack;
		logic error;
	} dec_state_t;

	dec_state_t st_reg;
	dec_state_t st_next;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
		input logic [23:0] bytes);
		in_range = (a >= lo) && (a <= (lo + bytes - 24'h000001));
	endfunction

	// Fixed on-chip areas win over the enable-gated windows, which win over external
	function automatic target_t decode(input logic [23:0] a, input logic periph_en);
		if (in_range(a, SFR_BASE, SFR_AREA_BYTES)) begin
			decode = TGT_SFR;
		end else if (in_range(a, EXTENDED_FUNCTION_REGS_BASE, SFR_AREA_BYTES)) begin
			decode = TGT_EXTENDED_FUNCTION_REGS;
		end else if (in_range(a, IRAM_BASE, IRAM_BYTES)) begin
			decode = TGT_IRAM;
		end else if (periph_en && a >= EXTENSION_RAM_BASE && a <= EXTENSION_RAM_LAST) begin
			decode = TGT_EXTENSION_RAM;
		end else if (periph_en && a >= CAN_BASE && a <= CAN_LAST) begin
			decode = TGT_CAN;
		end else begin
			decode = TGT_EXT;
		end
	endfunction

	function automatic logic bit_ok(input logic [23:0] a);
		bit_ok = in_range(a, BIT_IRAM_BASE, BIT_AREA_BYTES) ||
			in_range(a, BIT_SFR_BASE, BIT_AREA_BYTES) ||
			in_range(a, BIT_EXTENDED_FUNCTION_REGS_BASE, BIT_AREA_BYTES);
	endfunction

	// Window 4 overrides 3, 2 overrides 1; pairs are expected not to overlap
	function automatic logic [2:0] window_sel(input logic [23:0] a, input logic [3:0] en,
		input logic [47:0] base, input logic [47:0] mask);
		logic [2:0] sel;
		sel = 3'h0;
		for (int w = 0; w < NUM_WINDOWS; w++) begin
			if (en[w] && (((a[23:WIN_LSB] ^ base[w*12 +: 12]) & mask[w*12 +: 12]) == 12'h000)) begin
				sel = 3'(w + 1);
			end
		end
		window_sel = sel;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic periph_en;
	logic [23:0] eff_addr;
	target_t dec_target;
	logic refuse;

	always_comb begin
		periph_en = i_system_config_reg[PERIPH_EN_BIT];
		// Register bank: word register n at CP+2n, byte half n at CP+n
		if (i_gpr_access && i_word) begin
			eff_addr = i_context_ptr + {19'h00000, i_gpr_num, 1'b0};
		end else if (i_gpr_access) begin
			eff_addr = i_context_ptr + {20'h00000, i_gpr_num};
		end else begin
			eff_addr = i_addr;
		end
		dec_target = decode(eff_addr, periph_en);
		// Bank and stack live only in internal RAM; bit access only in bit areas
		refuse = 1'b0;
		if ((i_gpr_access || i_stack_access) && dec_target != TGT_IRAM) begin
			refuse = 1'b1;
		end
		if (i_bit_access && !bit_ok(eff_addr)) begin
			refuse = 1'b1;
		end
		if (i_bit_access && i_word) begin
			refuse = 1'b1;
		end

		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.error = 1'b0;
		// Segment line count follows the enable at all times
		st_next.seg_lines = periph_en ? CAN_SEG_LINES : FULL_SEG_LINES;

		unique case (st_reg.state)
			ST_IDLE: begin
				if (i_req && refuse) begin
					st_next.ack = 1'b1;
					st_next.error = 1'b1;
				end else if (i_req) begin
					st_next.target = dec_target;
					st_next.addr = eff_addr;
					st_next.word = i_word;
					st_next.write = i_write;
					st_next.bit_acc = i_bit_access;
					st_next.busy = 1'b1;
					st_next.bus_cfg = 3'h0;
					st_next.cs = 5'h00;
					st_next.wait_states = 2'h0;
					st_next.demux = 1'b0;
					st_next.count = ONCHIP_CNT;
					st_next.state = ST_WAIT;
					unique case (dec_target)
						TGT_EXTENSION_RAM: begin
							st_next.wait_states = EXTENSION_RAM_WAIT_STATES;
							st_next.demux = 1'b1;
							st_next.count = EXTENSION_RAM_CNT;
						end
						TGT_CAN: begin
							st_next.wait_states = CAN_WAIT_STATES;
							st_next.demux = 1'b1;
							st_next.count = CAN_CNT;
						end
						TGT_EXT: begin
							st_next.state = ST_EXT;
							st_next.bus_cfg = window_sel(eff_addr, i_window_enable,
								i_window_base, i_window_mask);
							st_next.cs = 5'h01 << window_sel(eff_addr, i_window_enable,
								i_window_base, i_window_mask);
							// Only A0..A19 reach the pins while CAN is in use; A20..A23 are cleared
							if (periph_en) begin
								st_next.addr = {4'h0, eff_addr[19:0]};
							end
						end
						default: begin
						end
					endcase
				end
			end
			ST_WAIT: begin
				if (st_reg.count == 5'h00) begin
					st_next.state = ST_IDLE;
					st_next.busy = 1'b0;
					st_next.ack = 1'b1;
					st_next.target = TGT_NONE;
				end else begin
					st_next.count = st_reg.count - 5'h01;
				end
			end
			ST_EXT: begin
				// External timing belongs to the bus controller; wait for its done
				if (i_ext_done) begin
					st_next.state = ST_IDLE;
					st_next.busy = 1'b0;
					st_next.ack = 1'b1;
					st_next.target = TGT_NONE;
					st_next.cs = 5'h00;
				end
			end
			default: begin
				st_next.state = ST_IDLE;
				st_next.busy = 1'b0;
				st_next.target = TGT_NONE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_reg <= '{state: ST_IDLE, count: 5'h00, target: TGT_NONE, addr: 24'h000000,
				word: 1'b0, write: 1'b0, bit_acc: 1'b0, bus_cfg: 3'h0, cs: 5'h00,
				wait_states: 2'h0, demux: 1'b0, seg_lines: FULL_SEG_LINES, busy: 1'b0,
				ack: 1'b0, error: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_target = st_reg.target;
	assign o_addr = st_reg.addr;
	assign o_word = st_reg.word;
	assign o_write = st_reg.write;
	assign o_bit_access = st_reg.bit_acc;
	assign o_bus_config_sel = st_reg.bus_cfg;
	assign o_chip_select = st_reg.cs;
	assign o_wait_states = st_reg.wait_states;
	assign o_demux = st_reg.demux;
	assign o_segment_lines = st_reg.seg_lines;
	assign o_busy = st_reg.busy;
	assign o_ack = st_reg.ack;
	assign o_error = st_reg.error;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic plain_req;
	assign plain_req = i_req && !st_reg.busy && !i_gpr_access && !i_bit_access &&
		!i_stack_access;

	AST_EXTENSION_RAM_DISABLED_EXT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		plain_req && !i_system_config_reg[PERIPH_EN_BIT] && i_addr >= EXTENSION_RAM_BASE &&
		i_addr <= EXTENSION_RAM_LAST |=> o_target == TGT_EXT && o_busy)
		else $error("disabled extension RAM range not sent external");

	AST_EXTENSION_RAM_ENABLED_MAP: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		plain_req && i_system_config_reg[PERIPH_EN_BIT] && i_addr >= EXTENSION_RAM_BASE &&
		i_addr <= EXTENSION_RAM_LAST |=> o_target == TGT_EXTENSION_RAM)
		else $error("enabled extension RAM range not mapped on chip");

	AST_EXTENSION_RAM_TIME: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		$rose(o_target == TGT_EXTENSION_RAM) |-> !o_ack [*8] ##1 o_ack && !o_error)
		else $error("extension RAM access length wrong");

	AST_CAN_TIME: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		$rose(o_target == TGT_CAN) |-> o_wait_states == CAN_WAIT_STATES && o_demux
		##CAN_DLY o_ack)
		else $error("CAN access mode or length wrong");

	AST_EXTENSION_RAM_MODE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_target == TGT_EXTENSION_RAM |-> o_wait_states == EXTENSION_RAM_WAIT_STATES && o_demux)
		else $error("extension RAM bus mode wrong");

	AST_EXTENSION_RAM_NO_STACK: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_req && !st_reg.busy && i_stack_access && i_system_config_reg[PERIPH_EN_BIT] &&
		i_addr >= EXTENSION_RAM_BASE && i_addr <= EXTENSION_RAM_LAST && !i_gpr_access |=> o_ack && o_error)
		else $error("stack access to extension RAM not refused");

	AST_EXTENSION_RAM_NO_BIT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_req && !st_reg.busy && i_bit_access && !i_gpr_access &&
		i_addr >= EXTENSION_RAM_BASE && i_addr <= EXTENSION_RAM_LAST |=> o_error && !o_busy)
		else $error("bit access to extension RAM not refused");

	AST_SEG_LINES: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		##1 o_segment_lines == ($past(i_system_config_reg[PERIPH_EN_BIT]) ?
		CAN_SEG_LINES : FULL_SEG_LINES))
		else $error("segment line count wrong");

	AST_CAN_EXT_MASK: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_target == TGT_EXT && o_segment_lines == CAN_SEG_LINES && $rose(o_busy) |->
		o_addr[23:20] == 4'h0)
		else $error("external address above segment lines with CAN");

	AST_EXT_ONE_CS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_target == TGT_EXT |-> $onehot(o_chip_select) &&
		o_chip_select == (5'h01 << o_bus_config_sel))
		else $error("external chip select not one-hot");

	AST_SIZE_FWD: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_req && !st_reg.busy && !refuse |=> o_word == $past(i_word) && o_busy)
		else $error("access size not forwarded");

	AST_SFR_FIRST: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		plain_req && in_range(i_addr, SFR_BASE, SFR_AREA_BYTES) |=> o_target == TGT_SFR
		##1 o_ack)
		else $error("register area not claimed on chip");

	AST_IRAM_MAP: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		plain_req && in_range(i_addr, IRAM_BASE, IRAM_BYTES) |=> o_target == TGT_IRAM
		##1 o_ack)
		else $error("internal RAM access not claimed on chip");

	AST_CAN_DISABLED_EXT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		plain_req && !i_system_config_reg[PERIPH_EN_BIT] && i_addr >= CAN_BASE &&
		i_addr <= CAN_LAST |=> o_target == TGT_EXT)
		else $error("disabled CAN window not sent external");

	AST_EXT_DEFAULT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		plain_req && !i_system_config_reg[PERIPH_EN_BIT] && i_addr[23:16] != 8'h00 |=>
		o_target == TGT_EXT && o_busy)
		else $error("unclaimed access not sent external");

	AST_GPR_ADDR: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_req && !st_reg.busy && i_gpr_access && i_word && !refuse |=>
		o_addr == $past(i_context_ptr) + {19'h00000, $past(i_gpr_num), 1'b0})
		else $error("register bank word address wrong");

	AST_REFUSE_PULSE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_req && !st_reg.busy && refuse |=> o_ack && o_error && !o_busy)
		else $error("refused access not answered with error");

	COV_EXTENSION_RAM: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_target == TGT_EXTENSION_RAM ##[1:20] o_ack);
	COV_CAN: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_target == TGT_CAN ##[1:20] o_ack);
	COV_EXT_WIN: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_target == TGT_EXT && o_bus_config_sel != 3'h0);
	COV_ERROR: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_ack && o_error);

endmodule

/* rtl/memory_map_pkg.sv */
// What this block does
// - One 16M Byte linear map for everything
// - Byte and word access everywhere, size forwarded
// - Bit addressing only in chosen on-chip areas
// - 2K Byte dual-port internal RAM
// - Register bank: 16 words, low eight bytewise
// - 2K Byte single-port extension RAM
// - Extension RAM: demux 16-bit, no waits, 80ns
// - Peripheral enable maps extension RAM E000-E7FF
// - Extension RAM refuses stack and register banks
// - Extension RAM refuses bit access
// - Disabled extension RAM range goes external
// - 1024 Byte reserved as two 512 Byte areas
// - CAN window EF00-EFFF under same enable bit
// - CAN: demux 16-bit, two waits, 160ns
// - CAN in use: four segment lines only
// - Unclaimed accesses go to external memory
// - Outside all windows, default bus config applies
package memory_map_pkg;

	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam logic [23:0] EXTENSION_RAM_BASE = 24'h00E000;
	localparam logic [23:0] EXTENSION_RAM_LAST = 24'h00E7FF;
	localparam logic [23:0] CAN_BASE = 24'h00EF00;
	localparam logic [23:0] CAN_LAST = 24'h00EFFF;
	localparam logic [23:0] IRAM_BYTES = 24'h000800;
	localparam logic [23:0] SFR_AREA_BYTES = 24'h000200;
	localparam logic [23:0] BIT_AREA_BYTES = 24'h000100;
	localparam int PERIPH_EN_BIT = 2;
	localparam int NUM_WINDOWS = 4;
	localparam int WIN_LSB = 12;

	// ------------------------------------------------------------
	// Bus modes and timing
	// ------------------------------------------------------------
	localparam logic [1:0] EXTENSION_RAM_WAIT_STATES = 2'h0;
	localparam logic [1:0] CAN_WAIT_STATES = 2'h2;
	localparam logic [3:0] FULL_SEG_LINES = 4'h8;
	localparam logic [3:0] CAN_SEG_LINES = 4'h4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int EXTENSION_RAM_ACCESS_NS = 80;
	localparam int CAN_ACCESS_NS = 160;
	localparam int EXTENSION_RAM_ACCESS_CYC = (EXTENSION_RAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAN_ACCESS_CYC = (CAN_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ONCHIP_ACCESS_CYC = 1;

	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_IRAM = 3'b001,
		TGT_SFR = 3'b010,
		TGT_EXTENDED_FUNCTION_REGS = 3'b011,
		TGT_EXTENSION_RAM = 3'b100,
		TGT_CAN = 3'b101,
		TGT_EXT = 3'b110
	} target_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_EXT = 2'b10
	} state_t;

endpackage

/* verification/access_master_model.sv */
`timescale 1ns/1ps
module access_master_model (
	input wire logic i_ref_clk,
	input wire logic i_busy,
	input wire logic i_ack,
	input wire logic i_error,
	input wire logic [2:0] i_target,
	input wire logic [4:0] i_chip_select,
	output logic o_req,
	output logic [23:0] o_addr,
	output logic o_word,
	output logic o_write,
	output logic o_bit_access,
	output logic o_stack_access,
	output logic o_gpr_access,
	output logic [3:0] o_gpr_num,
	output logic o_ext_done
);
	int ext_delay = 3;
	int ext_cnt = 0;
	int cap_cyc = 0;
	logic cap_err;
	logic [2:0] cap_tgt;
	logic [4:0] cap_cs;

	initial begin
		o_req = 1'h0;
		o_addr = 24'h0;
		o_word = 1'h0;
		o_write = 1'h0;
		o_bit_access = 1'h0;
		o_stack_access = 1'h0;
		o_gpr_access = 1'h0;
		o_gpr_num = 4'h0;
	end

	// ------------------------------------------------------------
	// External bus controller stand-in
	// ------------------------------------------------------------
	// One-cycle done pulse after ext_delay cycles of an external access
	always @(negedge i_ref_clk) begin
		o_ext_done <= 1'h0;
		if (i_busy === 1'h1 && i_target === 3'h6) begin
			ext_cnt <= ext_cnt + 1;
			if (ext_cnt + 1 == ext_delay) begin
				o_ext_done <= 1'h1;
			end
		end else begin
			ext_cnt <= 0;
		end
	end

	// ------------------------------------------------------------
	// Master access
	// ------------------------------------------------------------
	// Only called while idle, so the first rising edge takes the request.
	// Qualifiers stay put until the next access; write toggles each time.
	task automatic access(input logic [23:0] a, input logic w, input logic [2:0] k,
		input logic [3:0] n);
		@(negedge i_ref_clk);
		o_addr = a;
		o_word = w;
		o_write = ~o_write;
		{o_bit_access, o_stack_access, o_gpr_access} = k;
		o_gpr_num = n;
		o_req = 1'h1;
		@(negedge i_ref_clk);
		o_req = 1'h0;
		cap_tgt = i_target;
		cap_cs = i_chip_select;
		cap_cyc = 1;
		while (i_ack !== 1'h1 && cap_cyc < 400) begin
			@(negedge i_ref_clk);
			cap_cyc++;
		end
		cap_err = i_error;
	endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import memory_map_pkg::*;
	localparam int ON = ONCHIP_ACCESS_CYC + 1;
	localparam int XR = EXTENSION_RAM_ACCESS_CYC + 1;
	localparam int CN = CAN_ACCESS_CYC + 1;
	logic i_ref_clk, i_sys_rst, i_req, i_word, i_write, i_bit_access, i_stack_access;
	logic i_gpr_access, i_ext_done, o_word, o_write, o_bit_access, o_demux, o_busy;
	logic o_ack, o_error;
	logic [3:0] i_gpr_num, i_window_enable, o_segment_lines;
	logic [23:0] i_addr, i_context_ptr, o_addr;
	logic [15:0] i_system_config_reg;
	logic [47:0] i_window_base, i_window_mask;
	logic [2:0] o_target, o_bus_config_sel;
	logic [4:0] o_chip_select;
	logic [1:0] o_wait_states;
	int n_mismatch = 0;
	int cmp_count = 0;

	memory_map_address_decoder dut (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_addr(i_addr),
		.i_word(i_word), .i_write(i_write), .i_bit_access(i_bit_access),
		.i_stack_access(i_stack_access), .i_gpr_access(i_gpr_access), .i_gpr_num(i_gpr_num),
		.i_context_ptr(i_context_ptr), .i_system_config_reg(i_system_config_reg),
		.i_window_enable(i_window_enable), .i_window_base(i_window_base),
		.i_window_mask(i_window_mask), .i_ext_done(i_ext_done), .o_target(o_target),
		.o_addr(o_addr), .o_word(o_word), .o_write(o_write), .o_bit_access(o_bit_access),
		.o_bus_config_sel(o_bus_config_sel), .o_chip_select(o_chip_select),
		.o_wait_states(o_wait_states), .o_demux(o_demux), .o_segment_lines(o_segment_lines),
		.o_busy(o_busy), .o_ack(o_ack), .o_error(o_error)
	);

	access_master_model mdl (
		.i_ref_clk(i_ref_clk), .i_busy(o_busy), .i_ack(o_ack), .i_error(o_error),
		.i_target(o_target), .i_chip_select(o_chip_select), .o_req(i_req), .o_addr(i_addr),
		.o_word(i_word), .o_write(i_write), .o_bit_access(i_bit_access),
		.o_stack_access(i_stack_access), .o_gpr_access(i_gpr_access), .o_gpr_num(i_gpr_num),
		.o_ext_done(i_ext_done)
	);

	initial begin
		i_ref_clk = 1'h0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic setcfg(input logic en, input logic [3:0] wen, input logic [47:0] base,
		input logic [47:0] mask);
		@(negedge i_ref_clk);
		i_system_config_reg = {13'h0, en, 2'h0};
		i_window_enable = wen;
		i_window_base = base;
		i_window_mask = mask;
	endtask

	// k is {bit, stack, register bank}
	task automatic go(input logic [23:0] a, input logic w, input logic [2:0] k,
		input logic [3:0] n, input logic [2:0] tgt, input int cyc, input logic err);
		mdl.access(a, w, k, n);
		if (mdl.cap_cyc >= 400) begin
			n_mismatch++;
			close_out();
		end
		check(mdl.cap_tgt, tgt);
		check(mdl.cap_cyc, cyc);
		check({mdl.cap_err, o_busy}, {err, 1'h0});
		if (!err) check({o_word, o_write, o_bit_access}, {w, i_write, k[2]});
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_onchip();
		logic [23:0] a [6] = '{24'h00FE00, 24'h00FFFF, 24'h00F000, 24'h00F1FF,
			24'h00F600, 24'h00FDFF};
		logic [2:0] t [6] = '{TGT_SFR, TGT_SFR, TGT_EXTENDED_FUNCTION_REGS, TGT_EXTENDED_FUNCTION_REGS, TGT_IRAM, TGT_IRAM};
		for (int i = 0; i < 6; i++) begin
			go(a[i], ~i[0], 3'h0, 4'h0, t[i], ON, 1'h0);
		end
	endtask

	task automatic t_ext_ram_can();
		setcfg(1'h1, 4'h0, 48'h0, 48'hFFFFFFFFFFFF);
		go(24'h00E000, 1'h1, 3'h0, 4'h0, TGT_EXTENSION_RAM, XR, 1'h0);
		check({o_wait_states, o_demux}, {EXTENSION_RAM_WAIT_STATES, 1'h1});
		go(24'h00E7FF, 1'h0, 3'h0, 4'h0, TGT_EXTENSION_RAM, XR, 1'h0);
		go(24'h00E800, 1'h1, 3'h0, 4'h0, TGT_EXT, mdl.ext_delay + 1, 1'h0);
		go(24'h00EF00, 1'h1, 3'h0, 4'h0, TGT_CAN, CN, 1'h0);
		check({o_wait_states, o_demux}, {CAN_WAIT_STATES, 1'h1});
		go(24'h00EFFF, 1'h0, 3'h0, 4'h0, TGT_CAN, CN, 1'h0);
		go(24'h00E000, 1'h0, 3'h4, 4'h0, TGT_NONE, 1, 1'h1);
		go(24'h00E000, 1'h1, 3'h2, 4'h0, TGT_NONE, 1, 1'h1);
		setcfg(1'h0, 4'h0, 48'h0, 48'hFFFFFFFFFFFF);
		go(24'h00E000, 1'h1, 3'h0, 4'h0, TGT_EXT, mdl.ext_delay + 1, 1'h0);
		check(o_demux, 1'h0);
		go(24'h00EF00, 1'h1, 3'h0, 4'h0, TGT_EXT, mdl.ext_delay + 1, 1'h0);
	endtask

	task automatic t_windows();
		mdl.ext_delay = 1;
		setcfg(1'h0, 4'h3, {24'h0, 12'h010, 12'h010}, {24'h0, 12'hFFF, 12'hFF0});
		go(24'h010000, 1'h1, 3'h0, 4'h0, TGT_EXT, 2, 1'h0);
		check({o_bus_config_sel, mdl.cap_cs}, {3'h2, 5'h04});
		go(24'h01F000, 1'h1, 3'h0, 4'h0, TGT_EXT, 2, 1'h0);
		check({o_bus_config_sel, mdl.cap_cs}, {3'h1, 5'h02});
		go(24'h350001, 1'h0, 3'h0, 4'h0, TGT_EXT, 2, 1'h0);
		check({o_bus_config_sel, mdl.cap_cs, o_addr}, {3'h0, 5'h01, 24'h350001});
		go(24'h00F5FF, 1'h0, 3'h0, 4'h0, TGT_EXT, 2, 1'h0);
		mdl.ext_delay = 6;
		setcfg(1'h1, 4'h8, {12'h00F, 36'h0}, 48'hFFFFFFFFFFFF);
		go(24'h00F600, 1'h1, 3'h0, 4'h0, TGT_IRAM, ON, 1'h0);
		go(24'h350000, 1'h1, 3'h0, 4'h0, TGT_EXT, 7, 1'h0);
		check(o_addr, 24'h050000);
	endtask

	task automatic t_bank_bits();
		@(negedge i_ref_clk);
		i_context_ptr = 24'h00F600;
		go(24'h0, 1'h1, 3'h1, 4'hF, TGT_IRAM, ON, 1'h0);
		check(o_addr, 24'h00F61E);
		go(24'h0, 1'h0, 3'h1, 4'hF, TGT_IRAM, ON, 1'h0);
		check(o_addr, 24'h00F60F);
		go(24'h00FD00, 1'h0, 3'h4, 4'h0, TGT_IRAM, ON, 1'h0);
		go(24'h00FF00, 1'h0, 3'h4, 4'h0, TGT_SFR, ON, 1'h0);
		go(24'h00F100, 1'h0, 3'h4, 4'h0, TGT_EXTENDED_FUNCTION_REGS, ON, 1'h0);
		go(24'h00FD00, 1'h1, 3'h4, 4'h0, TGT_NONE, 1, 1'h1);
		go(24'h00F700, 1'h1, 3'h2, 4'h0, TGT_IRAM, ON, 1'h0);
		@(negedge i_ref_clk);
		i_context_ptr = 24'h00E000;
		go(24'h0, 1'h1, 3'h1, 4'h0, TGT_NONE, 1, 1'h1);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		i_sys_rst = 1'h1;
		i_system_config_reg = 16'h0;
		i_window_enable = 4'h0;
		i_window_base = 48'h0;
		i_window_mask = 48'hFFFFFFFFFFFF;
		i_context_ptr = 24'h00F600;
		repeat (6) @(posedge i_ref_clk);
		check({o_segment_lines, o_busy, o_ack}, {FULL_SEG_LINES, 2'h0});
		@(negedge i_ref_clk);
		i_sys_rst = 1'h0;
		setcfg(1'h1, 4'h0, 48'h0, 48'hFFFFFFFFFFFF);
		@(posedge i_ref_clk);
		#1 check(o_segment_lines, CAN_SEG_LINES);
		setcfg(1'h0, 4'h0, 48'h0, 48'hFFFFFFFFFFFF);
		@(posedge i_ref_clk);
		#1 check(o_segment_lines, FULL_SEG_LINES);
		t_onchip();
		t_ext_ram_can();
		t_windows();
		t_bank_bits();
		close_out();
	end

	// Hang guard
	initial begin
		#900000;
		n_mismatch++;
		close_out();
	end
endmodule
